// ==== sdet_codec.sv ====
// sdet_codec: (72,64) secded encoder and decoder under test
`timescale 1ns/1ps
`default_nettype none
module sdet_codec
  import sdet_pkg::*;
(
  input  wire logic [63:0] data_in,
  input  wire logic [71:0] cw_in,
  output logic      [71:0] enc_out,
  output sdet_dec_s        dec_out
);

  // ----------------------------------------------------------------
  // encoder and decoder paths
  // ----------------------------------------------------------------
  assign enc_out = sdet_encode(data_in);
  assign dec_out = sdet_decode(cw_in);

endmodule
`default_nettype wire

// ==== sdet_pkg.sv ====
// sdet_pkg: constants, types and secded functions of the ecc diagnostic tester
package sdet_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL  = 8'h00;  // test control word
  localparam logic [7:0] OFF_FLAGS = 8'h04;  // system_fault_word3, read only
  localparam logic [7:0] OFF_CLEAR = 8'h08;  // fault3_clear_reg, write 1 to clear
  localparam logic [7:0] OFF_IN0   = 8'h10;  // diag_input_bytes 0..8
  localparam logic [7:0] OFF_OUT0  = 8'h40;  // diag_output_bytes 0..8
  localparam logic [3:0] NUM_BYTES = 4'h9;

  // ----------------------------------------------------------------
  // field positions and word transfer size
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_EN_BIT    = 0;  // test enable
  localparam int unsigned CTRL_MAN_BIT   = 1;  // source select, 1 = manual
  localparam int unsigned CTRL_PATH_BIT  = 2;  // path_select, 1 = encoder
  localparam int unsigned CTRL_ETYPE_BIT = 3;  // error_type_select, 1 = double
  localparam int unsigned FLAG_SEC_BIT   = 0;  // single_error_flag / clear
  localparam int unsigned FLAG_DED_BIT   = 1;  // double_error_flag / clear
  localparam logic [2:0]  HSIZE_WORD     = 3'h2;

  // ----------------------------------------------------------------
  // codeword geometry and internal test patterns
  // ----------------------------------------------------------------
  localparam int unsigned CW_W   = 72;
  localparam int unsigned DATA_W = 64;
  localparam logic [71:0] AUTO_ENC_CW   = 72'hCD_3968_C140_2EA5_ED6D;
  localparam logic [63:0] AUTO_SEC_DATA = 64'h18C3_FF8A_68A9_8069;
  localparam logic [71:0] AUTO_SEC_FLIP = 72'h00_0000_0000_0000_0020;  // one data bit
  localparam logic [71:0] AUTO_DED_FLIP = 72'h00_0000_0000_0000_0003;  // p0 and p1

  typedef struct packed {
    logic [63:0] data;
    logic        sec;
    logic        ded;
  } sdet_dec_s;

  typedef struct packed {
    logic            enable;
    logic            manual;
    logic            path_enc;
    logic            etype_ded;
    logic            sflag;
    logic            dflag;
    logic [8:0][7:0] din;
    logic [8:0][7:0] dout;
    logic            wr_pend;
    logic            rd_pend;
    logic            hit;
    logic [7:0]      addr;
    logic [31:0]     rdata;
  } sdet_state_s;

  localparam sdet_state_s ST_RST = '0;

  // data bits sit at every position from 1 up that is not a power of two
  function automatic logic [63:0] sdet_extract(input logic [71:0] cw);
    logic [63:0] d;
    int          k;
    d = '0;
    k = 0;
    for (int p = 1; p < CW_W; p++) begin
      if ((p & (p - 1)) != 0) begin
        d[k] = cw[p];
        k++;
      end
    end
    return d;
  endfunction

  // parity pN at position N over positions with bit N set, p0 over all
  // every group, p0 included, is odd: the fixed encoder pattern needs it
  function automatic logic [71:0] sdet_encode(input logic [63:0] d);
    logic [71:0] c;
    logic        x;
    int          k;
    c = '0;
    k = 0;
    for (int p = 1; p < CW_W; p++) begin
      if ((p & (p - 1)) != 0) begin
        c[p] = d[k];
        k++;
      end
    end
    for (int b = 0; b < 7; b++) begin
      x = 1'b1;  // odd group parity
      for (int p = 1; p < CW_W; p++) begin
        if (((p >> b) & 1) == 1) x = x ^ c[p];
      end
      c[1 << b] = x;
    end
    c[0] = ~^c[71:1];  // odd over all 72 positions
    return c;
  endfunction

  // syndrome plus overall parity: correct one error, flag two
  function automatic sdet_dec_s sdet_decode(input logic [71:0] cw);
    sdet_dec_s   r;
    logic [6:0]  s;
    logic [71:0] c;
    logic        odd;
    s = 7'h7F;  // odd groups check to zero
    c = cw;
    for (int b = 0; b < 7; b++) begin
      for (int p = 1; p < CW_W; p++) begin
        if (((p >> b) & 1) == 1) s[b] = s[b] ^ cw[p];
      end
    end
    odd   = ~^cw;  // overall parity broken
    r.sec = odd;
    r.ded = !odd && (s != 7'h00);
    if (odd && (s != 7'h00) && (s < 7'h48)) c[s] = ~c[s];
    r.data = sdet_extract(c);
    return r;
  endfunction

  localparam logic [71:0] AUTO_SEC_CW = sdet_encode(AUTO_SEC_DATA) ^ AUTO_SEC_FLIP;
  localparam logic [71:0] AUTO_DED_CW = sdet_encode(64'h0) ^ AUTO_DED_FLIP;
  localparam logic [63:0] AUTO_ENC_DATA = sdet_extract(AUTO_ENC_CW);

endpackage

// ==== sdet_tb_top.sv ====
// sdet_tb_top: self-checking bench of the ecc diagnostic tester
`timescale 1ns/1ps
`default_nettype none
module sdet_tb_top
  import sdet_pkg::*;
;
  logic        CLK = 1'b0, RST = 1'b1, HSEL = 1'b1, HWRITE = 1'b0;
  logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA, rv;
  logic [1:0]  HTRANS = 2'h0, pf;
  logic [2:0]  HSIZE = HSIZE_WORD;
  logic        HREADYOUT, HRESP, SINGLE_ERROR_FLAG, DOUBLE_ERROR_FLAG;
  wire         HREADY = HREADYOUT;
  int          bad_count = 0, checks_done = 0, cyc = 0, p, q, seed = 32'h2352f45a;
  logic [63:0] d;
  logic [71:0] cw;
  logic [23:0] hi = 24'h00_0000;

  sdet_top sdet_top_inst (.CLK(CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SINGLE_ERROR_FLAG(SINGLE_ERROR_FLAG),
    .DOUBLE_ERROR_FLAG(DOUBLE_ERROR_FLAG));

  // clock and hang limit
  always #10 CLK = ~CLK;
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // bus and compare tasks
  // ----------------------------------------------------------------
  task test_done;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // wait for hready high at a falling edge, data taken there, then go on to the rising edge
  task hw;
    @(negedge CLK);
    while (HREADYOUT !== 1'b1) @(negedge CLK);
    rv = HRDATA;
    pf = {DOUBLE_ERROR_FLAG, SINGLE_ERROR_FLAG};
    @(posedge CLK);
  endtask
  task xf(input logic w, input logic [7:0] a, input logic [31:0] v);
    HTRANS <= 2'h2;
    HWRITE <= w;
    HADDR <= {hi, a};
    hw();
    HTRANS <= 2'h0;
    HWDATA <= v;
    hw();
  endtask
  task flags(input logic [1:0] e);
    xf(1'b0, OFF_FLAGS, 32'h0);
    chk("flag word", {30'h0, e}, rv);
    chk("flag pins", {30'h0, e}, {30'h0, pf});
  endtask
  task outs(input logic [71:0] e, input int n);
    for (int k = 0; k < n; k++) begin
      xf(1'b0, OFF_OUT0 + 8'(4 * k), 32'h0);
      chk("output byte", {24'h0, e[8*k+:8]}, rv);
    end
  endtask
  task ins(input logic [71:0] v);
    for (int k = 0; k < 9; k++) xf(1'b1, OFF_IN0 + 8'(4 * k), {24'h0, v[8*k+:8]});
  endtask
  // disable, clear both flags, then configure and enable
  task run(input logic [3:0] c);
    xf(1'b1, OFF_CTRL, 32'h0);
    xf(1'b1, OFF_CLEAR, 32'h3);
    xf(1'b1, OFF_CTRL, {28'h0, c});
  endtask
  // reference codeword: data at non power positions, odd hamming groups, odd overall parity
  function automatic logic [71:0] enc(input logic [63:0] v);
    logic [71:0] c;
    int          k;
    c = '0;
    k = 0;
    for (int i = 3; i < 72; i++) begin
      if ((i & (i - 1)) != 0) begin
        c[i] = v[k];
        k++;
      end
    end
    for (int b = 0; b < 7; b++) begin
      c[1 << b] = 1'b1;
      for (int i = 3; i < 72; i++) begin
        if (((i >> b) & 1) == 1 && (i & (i - 1)) != 0) c[1 << b] ^= c[i];
      end
    end
    c[0] = ~^c;
    return c;
  endfunction

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    flags(2'h0);
    xf(1'b0, 8'h0C, 32'h0);
    chk("unmapped", 32'h0, rv);
    run(4'h1);
    flags(2'h1);
    outs({8'h0, 64'h18C3_FF8A_68A9_8069}, 9);
    // flag word behind a nonzero upper address must read zero
    hi = 24'h00_0001;
    xf(1'b0, OFF_FLAGS, 32'h0);
    hi = 24'h00_0000;
    chk("unmapped high", 32'h0, rv);
    for (int t = 0; t < 2; t++) begin
      xf(1'b1, OFF_CTRL, t ? 32'hD : 32'h5);
      outs(72'hCD_3968_C140_2EA5_ED6D, 9);
      flags(2'h1);
    end
    xf(1'b1, OFF_CTRL, 32'h0);
    xf(1'b1, OFF_OUT0, 32'h5A);
    outs(72'hCD_3968_C140_2EA5_ED6D, 1);
    xf(1'b1, OFF_CLEAR, 32'h1);
    flags(2'h0);
    run(4'h9);
    flags(2'h2);
    outs(72'h0, 9);
    repeat (4) begin
      d = {$random(seed), $random(seed)};
      cw = enc(d);
      ins({8'h0, d});
      run(4'h7);
      outs(cw, 9);
      p = {$random(seed)} % 72;
      q = (p + 1 + {$random(seed)} % 71) % 72;
      cw[p] = ~cw[p];
      ins(cw);
      run(4'h3);
      flags(2'h1);
      outs({8'h0, d}, 9);
      cw[q] = ~cw[q];
      ins(cw);
      run(4'hB);
      flags(2'h2);
    end
    // reset in mid run wipes results and flags
    RST <= 1'b1;
    repeat (2) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    flags(2'h0);
    outs(72'h0, 9);
    test_done();
  end
endmodule
`default_nettype wire

// ==== sdet_top.sv ====
// sdet_top: ecc diagnostic tester with ahb-lite register slave
//
// Design decisions made here: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module sdet_top
  import sdet_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  output logic             SINGLE_ERROR_FLAG,
  output logic             DOUBLE_ERROR_FLAG
);

  sdet_state_s st;
  sdet_state_s next_st;
  logic [63:0] codec_data;
  logic [71:0] codec_cw;
  logic [71:0] enc_cw;
  sdet_dec_s   dec;
  logic        take;
  logic [4:0]  in_slot;
  logic [4:0]  out_slot;
  logic [31:0] rd_word;

  // ----------------------------------------------------------------
  // byte slot decode: {hit, index} for a run of nine words
  // ----------------------------------------------------------------
  function automatic logic [4:0] slot(input logic [7:0] a, input logic [7:0] base);
    logic [7:0] off;
    off = a - base;
    if ((a >= base) && (off[1:0] == 2'h0) && (off[7:2] < {2'h0, NUM_BYTES})) begin
      return {1'b1, off[5:2]};
    end
    return 5'h00;
  endfunction

  // ----------------------------------------------------------------
  // operand selection
  // ----------------------------------------------------------------
  // manual takes software bytes, auto takes the held patterns
  always_comb begin
    if (st.manual) begin
      codec_data = st.din[7:0];
      codec_cw   = st.din;
    end else begin
      codec_data = AUTO_ENC_DATA;
      codec_cw   = st.etype_ded ? AUTO_DED_CW : AUTO_SEC_CW;
    end
  end

  sdet_codec u_codec (
    .data_in (codec_data),
    .cw_in   (codec_cw),
    .enc_out (enc_cw),
    .dec_out (dec)
  );

  // ----------------------------------------------------------------
  // bus address phase and register slots
  // ----------------------------------------------------------------
  assign take     = HSEL && HREADY && HTRANS[1];
  assign in_slot  = slot(st.addr, OFF_IN0);
  assign out_slot = slot(st.addr, OFF_OUT0);

  // read value of the latched address, zero when unmapped
  always_comb begin
    rd_word = 32'h0000_0000;
    if (st.hit) begin
      if (st.addr == OFF_CTRL) begin
        rd_word[CTRL_EN_BIT]    = st.enable;
        rd_word[CTRL_MAN_BIT]   = st.manual;
        rd_word[CTRL_PATH_BIT]  = st.path_enc;
        rd_word[CTRL_ETYPE_BIT] = st.etype_ded;
      end else if (st.addr == OFF_FLAGS) begin
        rd_word[FLAG_SEC_BIT] = st.sflag;
        rd_word[FLAG_DED_BIT] = st.dflag;
      end else if (in_slot[4]) begin
        rd_word[7:0] = st.din[in_slot[3:0]];
      end else if (out_slot[4]) begin
        rd_word[7:0] = st.dout[out_slot[3:0]];
      end
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    // read data phase: one wait cycle, then registered data
    if (st.rd_pend) begin
      next_st.rdata   = rd_word;
      next_st.rd_pend = 1'b0;
    end
    // write data phase
    if (st.wr_pend) begin
      next_st.wr_pend = 1'b0;
      if (st.hit && (st.addr == OFF_CTRL)) begin
        next_st.enable    = HWDATA[CTRL_EN_BIT];
        next_st.manual    = HWDATA[CTRL_MAN_BIT];
        next_st.path_enc  = HWDATA[CTRL_PATH_BIT];
        next_st.etype_ded = HWDATA[CTRL_ETYPE_BIT];
      end else if (st.hit && (st.addr == OFF_CLEAR)) begin
        if (HWDATA[FLAG_SEC_BIT]) next_st.sflag = 1'b0;
        if (HWDATA[FLAG_DED_BIT]) next_st.dflag = 1'b0;
      end else if (st.hit && in_slot[4]) begin
        next_st.din[in_slot[3:0]] = HWDATA[7:0];
      end
    end
    // address phase capture
    if (take) begin
      next_st.addr    = HADDR[7:0];
      next_st.hit     = (HADDR[31:8] == 24'h00_0000);
      next_st.wr_pend = HWRITE && (HSIZE == HSIZE_WORD);
      next_st.rd_pend = !HWRITE;
    end
    // test engine, runs every cycle while enabled
    if (st.enable) begin
      if (st.path_enc) begin
        next_st.dout = enc_cw;
      end else begin
        next_st.dout = {8'h00, dec.data};
        // set wins over a clear in the same cycle
        if (dec.sec) next_st.sflag = 1'b1;
        if (dec.ded) next_st.dflag = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      st <= ST_RST;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign HRDATA            = st.rdata;
  assign HREADYOUT         = !st.rd_pend;
  assign HRESP             = 1'b0;
  assign SINGLE_ERROR_FLAG = st.sflag;
  assign DOUBLE_ERROR_FLAG = st.dflag;

endmodule
`default_nettype wire

// ==== sdet_top_assertions.sv ====
// sdet_top_assertions: port level checker of the ecc diagnostic tester
`timescale 1ns/1ps
`default_nettype none
module sdet_chk
  import sdet_pkg::*;
(
  input wire logic        CLK,
  input wire logic        RST,
  input wire logic        HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic [2:0]  HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic        HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic        HREADYOUT,
  input wire logic        HRESP,
  input wire logic        SINGLE_ERROR_FLAG,
  input wire logic        DOUBLE_ERROR_FLAG
);
  logic       tk;
  logic       tw;
  logic       thi;
  logic [7:0] ta;
  logic [3:0] ctl;
  wire        clr_s = tk && tw && !thi && (ta == OFF_CLEAR) && HWDATA[0];
  wire        clr_d = tk && tw && !thi && (ta == OFF_CLEAR) && HWDATA[1];

  default clocking @(posedge CLK); endclocking
  default disable iff (RST);

  // ----------------------------------------------------------------
  // shadow of the taken transfer and of the control word
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      tk  <= 1'b0;
      ctl <= 4'h0;
    end else begin
      tk <= HSEL && HREADY && HTRANS[1];
      if (HREADY) begin
        tw  <= HWRITE;
        ta  <= HADDR[7:0];
        thi <= |HADDR[31:8];
      end
      if (tk && tw && !thi && (ta == OFF_CTRL) && HREADY) ctl <= HWDATA[3:0];
    end
  end

  sequence rd_take;
    HSEL && HREADY && HTRANS[1] && !HWRITE;
  endsequence
  sequence rd_wait;
    !HREADYOUT ##1 HREADYOUT;
  endsequence

  chk_resp_okay: assert property (HRESP == 1'b0) else $error("slave response not okay");
  chk_read_wait: assert property (rd_take |=> rd_wait) else $error("read wait state wrong");
  chk_write_nowait: assert property (HSEL && HREADY && HTRANS[1] && HWRITE |=> HREADYOUT)
    else $error("write data phase stalled");
  chk_flag_read: assert property (rd_take ##0 (HADDR == {24'h0, OFF_FLAGS}) |=> ##1
    HRDATA == {30'h0, $past(DOUBLE_ERROR_FLAG), $past(SINGLE_ERROR_FLAG)}) else $error("flag word wrong");
  chk_unmapped_zero: assert property (rd_take ##0 (HADDR[31:8] != 24'h0) |=> ##1 HRDATA == 32'h0)
    else $error("unmapped read not zero");
  chk_enc_flags: assert property (ctl[0] && ctl[2] |=> !$rose(SINGLE_ERROR_FLAG) && !$rose(DOUBLE_ERROR_FLAG))
    else $error("encoder test raised a flag");
  chk_sec_auto: assert property (ctl == 4'h1 |=> SINGLE_ERROR_FLAG) else $error("single flag missing");
  chk_ded_auto: assert property (ctl == 4'h9 |=> DOUBLE_ERROR_FLAG) else $error("double flag missing");
  chk_flag_clear: assert property ($fell(SINGLE_ERROR_FLAG) |-> $past(clr_s) || $past(RST))
    else $error("single flag fell without clear");
  chk_dflag_clear: assert property ($fell(DOUBLE_ERROR_FLAG) |-> $past(clr_d) || $past(RST))
    else $error("double flag fell without clear");
endmodule

bind sdet_top sdet_chk sdet_chk_inst (
  .CLK(CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
  .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
  .SINGLE_ERROR_FLAG(SINGLE_ERROR_FLAG), .DOUBLE_ERROR_FLAG(DOUBLE_ERROR_FLAG)
);
`default_nettype wire
